/* design/pdsr_top.sv */
// Power-down sequencer: qualify supply fail, save settings, request system reset
`timescale 1ns/100ps

// Functional notes
// - The fail indication is taken on a dedicated event input that starts power-off handling.
// - The reset-request pin is set to its idle level from reset so it can later fire the reset generator.
// - A fail indication while idle is treated as power-off at once.
// - A fail indication while printing halts printing and is sampled again about ten milliseconds later.
// - If the re-sample still shows the fail indication, power-off is declared.
// - After power-off is declared, at least thirty-two bytes are written to the EEPROM first.
// - The save completes while the logic supply is still in range, so it starts at once with no waits.
// - When the writes are done the reset-request pin is driven high.
// - The EEPROM is reached over select, clock, data-out and data-in port pins.
// - No EEPROM access starts while reset is held.
module pdsr_top
  import pdsr_pkg::*;
(
  input  wire logic        clk,              // System clock, 200 MHz
  input  wire logic        reset,            // From reset generator, active high
  input  wire logic        supply_fail,      // Asynchronous supply fail indication
  input  wire logic        printing,         // Printer is in a print job
  input  wire logic [7:0]  save_data [SAVE_BYTES], // Settings image to save
  input  wire logic        eeprom_do,        // Data from EEPROM
  output logic             eeprom_cs,        // EEPROM chip select
  output logic             eeprom_sk,        // EEPROM serial clock
  output logic             eeprom_di,        // Data to EEPROM
  output logic             halt_print,       // Stop printing request
  output logic             power_off,        // Power-off declared
  output logic             reset_request_pin // To manual reset input of reset generator
);

  typedef enum logic [6:0] {
    ST_RUN    = 7'b0000001,
    ST_CHECK  = 7'b0000010,
    ST_WEN    = 7'b0000100,
    ST_WRITE  = 7'b0001000,
    ST_WAIT   = 7'b0010000,
    ST_RESET  = 7'b0100000,
    ST_START  = 7'b1000000
  } pdsr_st_e;

  pdsr_st_e         state;
  pdsr_st_e         next_state;
  logic             fail_level;
  logic             fail_pending;
  logic             clear_pending;
  logic [21:0]      delay_cnt;
  logic [BYTE_CNT_W-1:0] word_idx;
  pdsr_req_s        req;
  pdsr_pins_s       pins;
  logic             eng_busy;
  logic             eng_done;
  logic             delay_done;
  logic             last_word;
  logic [15:0]      word_data;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] pack_word(input logic [7:0] lo, input logic [7:0] hi);
    return {hi, lo};
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  pdsr_sync u_sync (
    .clk           (clk),
    .reset         (reset),
    .async_in      (supply_fail),
    .clear_pending (clear_pending),
    .level         (fail_level),
    .pending       (fail_pending)
  );

  pdsr_eeprom_if u_eeprom (
    .clk   (clk),
    .reset (reset),
    .req   (req),
    .do_in (eeprom_do),
    .pins  (pins),
    .busy  (eng_busy),
    .done  (eng_done)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign delay_done    = delay_cnt == 22'(RECHECK_CYCLES - 1);
  assign last_word     = word_idx == BYTE_CNT_W'(SAVE_BYTES / 2 - 1);
  assign word_data     = pack_word(save_data[{word_idx[3:0], 1'b0}],
                                   save_data[{word_idx[3:0], 1'b1}]);
  // Consume the event on leaving the re-check too, so a glitch does not re-arm it
  assign clear_pending = fail_pending &&
                         (state == ST_RUN || (state == ST_CHECK && delay_done));

  // Request is held only in save states and never under reset
  assign req.start = !reset && !eng_busy && !eng_done &&
                     (state == ST_WEN || state == ST_WRITE);
  assign req.cmd   = state == ST_WEN   ? PDSR_CMD_WEN :
                     state == ST_WRITE ? PDSR_CMD_WRITE : PDSR_CMD_IDLE;
  assign req.addr  = 7'(word_idx);
  assign req.data  = word_data;

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_START: next_state = ST_RUN;
      ST_RUN: begin
        if (fail_pending) begin
          if (printing)
            next_state = ST_CHECK;
          else
            next_state = ST_WEN;
        end
      end
      ST_CHECK: begin
        if (delay_done)
          next_state = fail_level ? ST_WEN : ST_RUN;
      end
      ST_WEN: begin
        if (eng_done)
          next_state = ST_WRITE;
      end
      ST_WRITE: begin
        if (eng_done)
          next_state = last_word ? ST_RESET : ST_WRITE;
      end
      ST_RESET: next_state = ST_RESET;
      ST_WAIT:  next_state = ST_RUN;
      default:  next_state = ST_START;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= ST_START;
      delay_cnt <= '0;
      word_idx  <= '0;
    end else begin
      state     <= next_state;
      delay_cnt <= state == ST_CHECK ? delay_cnt + 22'h000001 : 22'h000000;
      if (state == ST_WRITE && eng_done)
        word_idx <= word_idx + BYTE_CNT_W'(1);
    end
  end

  // Outputs are registered; reset-request idles low from reset
  always_ff @(posedge clk) begin
    if (reset) begin
      eeprom_cs         <= 1'b0;
      eeprom_sk         <= 1'b0;
      eeprom_di         <= 1'b0;
      halt_print        <= 1'b0;
      power_off         <= 1'b0;
      reset_request_pin <= 1'b0;
    end else begin
      eeprom_cs         <= pins.cs;
      eeprom_sk         <= pins.sk;
      eeprom_di         <= pins.di;
      halt_print        <= next_state != ST_RUN && next_state != ST_START;
      power_off         <= next_state == ST_WEN || next_state == ST_WRITE ||
                           next_state == ST_RESET;
      reset_request_pin <= next_state == ST_RESET;
    end
  end

endmodule // pdsr_top

/* design/pdsr_pkg.sv */
// Package for the power-down save and reset sequencer
package pdsr_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS     = 5000;
  localparam int RECHECK_DELAY_US  = 10000;
  localparam int RECHECK_CYCLES    = (RECHECK_DELAY_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int SK_HALF_NS        = 500;
  localparam int SK_HALF_CYCLES    = SK_HALF_NS / (CLK_PERIOD_PS / 1000);
  localparam int WRITE_WAIT_US     = 10;
  localparam int WRITE_WAIT_CYCLES = (WRITE_WAIT_US * 1000) / (CLK_PERIOD_PS / 1000);

  // ----------------------------------------
  // Save image and serial frame layout
  // ----------------------------------------
  localparam int        SAVE_BYTES  = 32;
  localparam int        ADDR_W      = 7;
  localparam int        FRAME_BITS  = 10;
  localparam int        BYTE_CNT_W  = 6;
  localparam logic [2:0] OP_WRITE   = 3'h5;
  localparam logic [2:0] OP_WEN     = 3'h4;
  localparam logic [6:0] WEN_ADDR   = 7'h60;

  typedef enum logic [2:0] {
    PDSR_CMD_IDLE  = 3'h0,
    PDSR_CMD_WEN   = 3'h1,
    PDSR_CMD_WRITE = 3'h2
  } pdsr_cmd_e;

  // Request from the sequencer to the serial engine
  typedef struct packed {
    logic        start;
    pdsr_cmd_e   cmd;
    logic [6:0]  addr;
    logic [15:0] data;
  } pdsr_req_s;

  // EEPROM port pins: select, clock, data to the part
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } pdsr_pins_s;

endpackage

/* design/pdsr_sync.sv */
// Two-stage synchroniser with a pending-event latch for the supply fail input
`timescale 1ns/100ps
module pdsr_sync
  import pdsr_pkg::*;
(
  input  wire logic clk,           // System clock
  input  wire logic reset,         // Synchronous reset, active high
  input  wire logic async_in,      // Raw supply fail indication
  input  wire logic clear_pending, // Sequencer consumed the event
  output logic      level,         // Synchronised level
  output logic      pending        // Latched assertion
);

  logic meta;

  // ----------------------------------------
  // Synchroniser and latch
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      meta    <= 1'b0;
      level   <= 1'b0;
      pending <= 1'b0;
    end else begin
      meta  <= async_in;
      level <= meta;
      // Set wins over clear so an event on the clear cycle is kept
      if (level)
        pending <= 1'b1;
      else if (clear_pending)
        pending <= 1'b0;
    end
  end

endmodule // pdsr_sync

/* design/pdsr_eeprom_if.sv */
// Three-wire serial EEPROM engine: write-enable and word-write frames
`timescale 1ns/100ps
module pdsr_eeprom_if
  import pdsr_pkg::*;
(
  input  wire logic       clk,     // System clock
  input  wire logic       reset,   // Synchronous reset, active high
  input  pdsr_req_s       req,     // Frame request
  input  wire logic       do_in,   // Data from the EEPROM
  output pdsr_pins_s      pins,    // Select, clock, data to EEPROM
  output logic            busy,    // Frame in progress
  output logic            done     // One-cycle pulse at frame end
);

  typedef enum logic [3:0] {
    ES_IDLE  = 4'b0001,
    ES_SHIFT = 4'b0010,
    ES_DESEL = 4'b0100,
    ES_POLL  = 4'b1000
  } pdsr_es_e;

  localparam int TOTAL_BITS = 1 + 2 + ADDR_W + 16;

  pdsr_es_e             state;
  logic [TOTAL_BITS-1:0] shreg;
  logic [5:0]            bitcnt;
  logic [15:0]           tcnt;
  logic                  is_write;
  logic                  tick;
  logic [5:0]            frame_len;
  logic [TOTAL_BITS-1:0] frame;
  logic                  do_q;

  // ----------------------------------------
  // Frame building
  // ----------------------------------------
  assign tick      = tcnt == 16'(SK_HALF_CYCLES - 1);
  assign frame_len = req.cmd == PDSR_CMD_WRITE ? 6'(TOTAL_BITS) : 6'(FRAME_BITS);
  assign frame     = req.cmd == PDSR_CMD_WRITE ? {OP_WRITE, req.addr, req.data}
                                               : {OP_WEN, WEN_ADDR, 16'h0000};

  always_ff @(posedge clk) begin
    if (reset) begin
      state    <= ES_IDLE;
      shreg    <= '0;
      bitcnt   <= '0;
      tcnt     <= '0;
      is_write <= 1'b0;
      pins     <= '0;
      busy     <= 1'b0;
      done     <= 1'b0;
      do_q     <= 1'b0;
    end else begin
      done <= 1'b0;
      do_q <= do_in;
      tcnt <= tick ? 16'h0000 : tcnt + 16'h0001;
      case (state)
        ES_IDLE: begin
          tcnt <= '0;
          if (req.start && req.cmd != PDSR_CMD_IDLE) begin
            state    <= ES_SHIFT;
            shreg    <= frame;
            bitcnt   <= frame_len;
            is_write <= req.cmd == PDSR_CMD_WRITE;
            pins.cs  <= 1'b1;
            pins.sk  <= 1'b0;
            pins.di  <= 1'b0;
            busy     <= 1'b1;
          end
        end
        ES_SHIFT: begin
          if (tick) begin
            if (!pins.sk) begin
              if (bitcnt == '0) begin
                state   <= ES_DESEL;
                pins.cs <= 1'b0;
                pins.di <= 1'b0;
              end else begin
                pins.di <= shreg[TOTAL_BITS-1];
                shreg   <= {shreg[TOTAL_BITS-2:0], 1'b0};
                bitcnt  <= bitcnt - 6'h01;
                pins.sk <= 1'b1;
              end
            end else begin
              pins.sk <= 1'b0;
            end
          end
        end
        ES_DESEL: begin
          if (tick) begin
            if (is_write) begin
              // Reselect and wait for the ready level on the data line
              state   <= ES_POLL;
              pins.cs <= 1'b1;
            end else begin
              state <= ES_IDLE;
              busy  <= 1'b0;
              done  <= 1'b1;
            end
          end
        end
        ES_POLL: begin
          if (tick && do_q) begin
            state   <= ES_IDLE;
            pins.cs <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b1;
          end
        end
        default: begin
          state <= ES_IDLE;
        end
      endcase
    end
  end

endmodule // pdsr_eeprom_if

/* verification/pdsr_eeprom_model.sv */
// Behavioural serial EEPROM on the far side of the save port
`timescale 1ns/100ps
module pdsr_eeprom_model
  import pdsr_pkg::*;
(
  input  wire logic clk,   // System clock
  input  wire logic cs,    // Chip select
  input  wire logic sk,    // Serial clock
  input  wire logic di,    // Data into the part
  output logic      do_out // Ready status out of the part
);
  logic [15:0] mem [16];
  logic [25:0] sh;
  int          nb, nwr, nbad, busy;
  logic        wen_ok;
  initial begin
    do_out = 1'b0;
    wen_ok = 1'b0;
    nwr = 0;
    nbad = 0;
    busy = 0;
  end
  always @(posedge cs) begin
    sh = '0;
    nb = 0;
  end
  // Shift on the falling clock, when the data bit has settled
  always @(negedge sk) if (cs) begin
    sh = {sh[24:0], di};
    nb++;
  end
  always @(negedge cs) begin
    if (nb == 10 && sh[9:0] === {OP_WEN, WEN_ADDR}) wen_ok = 1'b1;
    else if (nb == 26 && wen_ok && sh[25:23] === OP_WRITE) begin
      mem[sh[19:16]] = sh[15:0];
      nwr++;
      busy = 300;
    end else if (nb != 0) nbad++;
  end
  // Slow write cycle; deselected output keeps toggling so a stale level never reads as ready
  always @(posedge clk) begin
    if (busy > 0) busy--;
    do_out <= cs ? (busy == 0) : ~do_out;
  end
endmodule // pdsr_eeprom_model

/* verification/pdsr_monitor.sv */
// Port checker for the power-down sequencer
`timescale 1ns/100ps
module pdsr_monitor
  import pdsr_pkg::*;
(
  input wire logic clk,              // System clock
  input wire logic reset,            // Synchronous reset
  input wire logic supply_fail,      // Fail indication
  input wire logic printing,         // Print job active
  input wire logic eeprom_cs,        // EEPROM select
  input wire logic eeprom_sk,        // EEPROM clock
  input wire logic halt_print,       // Halt request
  input wire logic power_off,        // Power-off declared
  input wire logic reset_request_pin // Reset request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] hi;
  always_ff @(posedge clk) hi <= eeprom_sk ? hi + 8'h01 : 8'h00;
  property p_reset_quiet; $fell(reset) |-> !(eeprom_cs || halt_print || power_off || reset_request_pin); endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
  property p_idle_fail; $rose(supply_fail) && !printing && !halt_print |-> ##[2:8] power_off; endproperty
  a_idle_fail: assert property (p_idle_fail) else $error("idle fail not declared");
  property p_print_halt; $rose(supply_fail) && printing && !halt_print |-> ##[2:8] (halt_print && !power_off); endproperty
  a_print_halt: assert property (p_print_halt) else $error("print fail not halted");
  property p_off_stands; power_off |=> power_off && halt_print; endproperty
  a_off_stands: assert property (p_off_stands) else $error("power-off dropped");
  property p_cs_after_off; $rose(eeprom_cs) |-> power_off; endproperty
  a_cs_after_off: assert property (p_cs_after_off) else $error("access before power-off");
  property p_req_rise; $rose(reset_request_pin) |-> power_off && !eeprom_cs; endproperty
  a_req_rise: assert property (p_req_rise) else $error("reset request out of turn");
  property p_req_stands; reset_request_pin |=> reset_request_pin && !eeprom_cs; endproperty
  a_req_stands: assert property (p_req_stands) else $error("reset request dropped");
  property p_sk_half; $fell(eeprom_sk) |-> hi == SK_HALF_CYCLES; endproperty
  a_sk_half: assert property (p_sk_half) else $error("serial clock high time wrong");
endmodule // pdsr_monitor
bind pdsr_top pdsr_monitor i_mon (.clk(clk), .reset(reset), .supply_fail(supply_fail), .printing(printing),
  .eeprom_cs(eeprom_cs), .eeprom_sk(eeprom_sk), .halt_print(halt_print), .power_off(power_off),
  .reset_request_pin(reset_request_pin));

/* verification/tb_power_down_save_and_reset.sv */
// Testbench for the power-down save and reset sequencer
`timescale 1ns/100ps
module tb_power_down_save_and_reset
  import pdsr_pkg::*;
;
  logic       clk = 1'b0, reset = 1'b1, supply_fail = 1'b0, printing = 1'b0;
  logic [7:0] save_data [SAVE_BYTES];
  logic       eeprom_do, eeprom_cs, eeprom_sk, eeprom_di, halt_print, power_off, reset_request_pin;
  int         bad_count = 0, check_count = 0;
  pdsr_top i_dut (.clk(clk), .reset(reset), .supply_fail(supply_fail), .printing(printing),
    .save_data(save_data), .eeprom_do(eeprom_do), .eeprom_cs(eeprom_cs), .eeprom_sk(eeprom_sk),
    .eeprom_di(eeprom_di), .halt_print(halt_print), .power_off(power_off),
    .reset_request_pin(reset_request_pin));
  pdsr_eeprom_model i_mem (.clk(clk), .cs(eeprom_cs), .sk(eeprom_sk), .di(eeprom_di), .do_out(eeprom_do));
  initial forever #2.5 clk = ~clk;
  task chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task test_done();
    if (bad_count == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task do_reset();
    reset = 1'b1;
    repeat (16) @(negedge clk);
    reset = 1'b0;
  endtask
  // Full recheck takes ten milliseconds, far past the run budget, so only the hold-off is seen
  task t_print_fail();
    printing = 1'b1;
    repeat (4) @(negedge clk);
    supply_fail = 1'b1;
    repeat (10) @(negedge clk);
    chk(halt_print === 1'b1 && power_off === 1'b0, "print not halted");
    repeat (2000) @(negedge clk);
    chk(power_off === 1'b0 && eeprom_cs === 1'b0, "save before recheck");
    supply_fail = 1'b0;
    printing = 1'b0;
  endtask
  task t_idle_save();
    int n;
    chk(halt_print === 1'b0 && reset_request_pin === 1'b0, "outputs not idle");
    repeat (4) @(negedge clk);
    supply_fail = 1'b1;
    repeat (8) @(negedge clk);
    chk(power_off === 1'b1, "idle fail not taken");
    n = 0;
    while (reset_request_pin !== 1'b1 && n < 95000) begin
      @(negedge clk);
      n++;
    end
    chk(n < 95000, "save timed out");
    chk(i_mem.nwr == 16 && i_mem.nbad == 0, "frame count");
    for (int k = 0; k < 16; k++) chk(i_mem.mem[k] === {save_data[2*k+1], save_data[2*k]}, "saved word");
    repeat (4) @(negedge clk);
    chk(reset_request_pin === 1'b1 && eeprom_cs === 1'b0, "no reset request");
  endtask
  initial begin
    for (int i = 0; i < SAVE_BYTES; i++) save_data[i] = 8'(i * 8'h35) ^ 8'hA5;
    do_reset();
    t_print_fail();
    do_reset();
    t_idle_save();
    test_done();
  end
  // Save of sixteen words takes about 94,000 cycles; allow a small margin
  initial begin
    repeat (99000) @(posedge clk);
    bad_count++;
    test_done();
  end
endmodule // tb_power_down_save_and_reset
